// ---- common/addressing_pkg.sv ----
// shared constants and types for operand addressing and status flags
package addressing_pkg;

  // status register location and field positions
  localparam logic [11:0] FLAGS_ADDR      = 12'h0fc;
  localparam int          CARRY_BIT       = 7;
  localparam int          ZERO_BIT        = 6;
  localparam int          SIGN_BIT        = 5;
  localparam int          OVERFLOW_BIT    = 4;
  localparam int          DEC_DIR_BIT     = 3;
  localparam int          HALF_CARRY_BIT  = 2;
  localparam int          WDOG_BIT        = 1;
  localparam int          STOP_BIT        = 0;
  localparam logic        WDOG_RESET_VAL  = 1'b0;

  // 8-bit register numbers in this group are working registers
  localparam logic [3:0]  WORK_GROUP_TAG  = 4'he;

  // condition field encodings
  localparam logic [3:0]  CC_NEVER  = 4'h0;
  localparam logic [3:0]  CC_LT     = 4'h1;
  localparam logic [3:0]  CC_LE     = 4'h2;
  localparam logic [3:0]  CC_ULE    = 4'h3;
  localparam logic [3:0]  CC_OV     = 4'h4;
  localparam logic [3:0]  CC_MI     = 4'h5;
  localparam logic [3:0]  CC_Z      = 4'h6;
  localparam logic [3:0]  CC_C      = 4'h7;
  localparam logic [3:0]  CC_ALWAYS = 4'h8;
  localparam logic [3:0]  CC_GE     = 4'h9;
  localparam logic [3:0]  CC_GT     = 4'ha;
  localparam logic [3:0]  CC_UGT    = 4'hb;
  localparam logic [3:0]  CC_NOV    = 4'hc;
  localparam logic [3:0]  CC_PL     = 4'hd;
  localparam logic [3:0]  CC_NZ     = 4'he;
  localparam logic [3:0]  CC_NC     = 4'hf;

  typedef enum logic [2:0] {
    MODE_REG_LONG, MODE_REG_SHORT, MODE_INDIRECT_RF, MODE_INDIRECT_PM,
    MODE_INDEXED, MODE_DIRECT, MODE_RELATIVE, MODE_IMMEDIATE
  } addr_mode_e;

  typedef enum logic [3:0] {
    FL_NONE, FL_ADD, FL_SUB, FL_LOGIC, FL_SHIFT, FL_BITTEST, FL_SET_C, FL_CLR_C, FL_CPL_C
  } flag_op_e;

  typedef struct packed {
    logic        valid;
    addr_mode_e  mode;
    logic        is_load;
    logic [7:0]  reg8;
    logic [3:0]  wreg;
    logic [7:0]  disp;
    logic [15:0] direct;
    logic [7:0]  imm;
  } addr_req_s;

  typedef struct packed {
    logic        done;
    logic        err;
    addr_mode_e  mode;
    logic [11:0] rf_addr;
    logic [15:0] pm_addr;
    logic [15:0] target;
    logic [7:0]  imm;
  } addr_res_s;

  typedef struct packed {
    logic        valid;
    flag_op_e    op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic        use_carry;
    logic [7:0]  result;
    logic        shift_out;
  } flag_req_s;

endpackage : addressing_pkg

// ---- logic/operand_addressing_and_flags.sv ----
// operand and branch address generation plus processor status flag register
`timescale 1ns/10ps

// Function
// RULE_01 - long register mode: 8-bit address selects a register in the current page
// RULE_02 - short register mode: 4-bit number joined with register pointer gives 12 bits
// RULE_03 - indirect mode: named register contents become the operand address
// RULE_04 - indirect program memory address comes from an even register pair
// RULE_05 - indexed mode only for load; address is offset plus working register
// RULE_06 - direct mode supplies next instruction address for jump and call
// RULE_07 - relative mode adds signed 8-bit displacement to next-instruction counter
// RULE_08 - immediate mode takes operand from instruction field, no address formed
// RULE_09 - source operand registers are only read, never modified
// RULE_10 - eight-bit status register at FCH, read and write like any register
// RULE_11 - carry: carry or borrow at bit 7, last bit shifted out, set/clear/invert
// RULE_12 - zero set when result or bit-test result is zero
// RULE_13 - sign copies result msb after arithmetic, logical, rotate or shift
// RULE_14 - overflow set on signed range exceed; logical ops clear it
// RULE_15 - decimal direction set after subtract, cleared after add
// RULE_16 - half carry set on carry out of or borrow into bit 3
// RULE_17 - only carry, zero, sign, overflow serve as jump conditions
// RULE_18 - watchdog flag set on timeout, cleared by reset pin
// RULE_19 - reset alters only watchdog and stop flags; others keep values
// RULE_20 - software clears watchdog and stop flags after testing them
// RULE_21 - software writes flags only with instructions that leave flags alone
// RULE_22 - pointer upper nibble picks working group, lower nibble picks page
// RULE_23 - 4-bit condition field chooses one of sixteen flag tests
// RULE_24 - relative target uses sign extension and 16-bit wraparound
// RULE_25 - explicit status register write beats same-cycle flag update
module operand_addressing_and_flags
  import addressing_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // sequencer request and answer
  input  wire addr_req_s   addr_req,
  input  wire logic [15:0] pc_next,
  input  wire logic [7:0]  register_pointer,
  output addr_res_s        addr_res_q,
  output logic             busy_q,
  // register file read path for pointer and index fetch
  output logic             rf_rd_q,
  output logic [11:0]      rf_raddr_q,
  input  wire logic [7:0]  rf_rdata,
  // status register access as an ordinary register
  input  wire logic        reg_wr_en,
  input  wire logic [11:0] reg_wr_addr,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic        reg_rd_en,
  input  wire logic [11:0] reg_rd_addr,
  output logic [7:0]       reg_rd_data_q,
  output logic             reg_rd_hit_q,
  // flag updates from the alu
  input  wire flag_req_s   flag_req,
  // condition test
  input  wire logic [3:0]  condition_field,
  output logic             cond_true_q,
  // system events
  input  wire logic        wdog_expire,
  input  wire logic        stop_wake,
  // flag register contents
  output logic [7:0]       flags_q
);

  typedef enum {ST_IDLE, ST_WAIT1, ST_DATA1, ST_WAIT2, ST_DATA2} fetch_state_e;

  fetch_state_e state_q;
  fetch_state_e state_d;
  addr_req_s    req_q;
  logic [7:0]   ptr_hi_q;
  logic [5:0]   arith_d;
  logic         flags_wr;
  logic [5:0]   arith_q;
  logic         wdog_q;
  logic         stop_q;

  // 12-bit register address for an 8-bit register number
  function automatic logic [11:0] rf_long(input logic [7:0] r, input logic [7:0] rp);
    if (r[7:4] == WORK_GROUP_TAG) begin
      rf_long = {rp[3:0], rp[7:4], r[3:0]};
    end else begin
      rf_long = {rp[3:0], r};                                       // see RULE_01
    end
  endfunction : rf_long

  // 12-bit register address for a working register number
  function automatic logic [11:0] rf_short(input logic [3:0] w, input logic [7:0] rp);
    rf_short = {rp[3:0], rp[7:4], w};                               // see RULE_02 see RULE_22
  endfunction : rf_short

  function automatic logic cond_test(input logic [3:0] cc, input logic [7:0] f);
    logic c;
    logic z;
    logic s;
    logic v;
    c = f[CARRY_BIT];
    z = f[ZERO_BIT];
    s = f[SIGN_BIT];
    v = f[OVERFLOW_BIT];
    case (cc)                                                       // see RULE_17 see RULE_23
      CC_NEVER:  cond_test = 1'b0;
      CC_LT:     cond_test = s ^ v;
      CC_LE:     cond_test = z | (s ^ v);
      CC_ULE:    cond_test = c | z;
      CC_OV:     cond_test = v;
      CC_MI:     cond_test = s;
      CC_Z:      cond_test = z;
      CC_C:      cond_test = c;
      CC_ALWAYS: cond_test = 1'b1;
      CC_GE:     cond_test = ~(s ^ v);
      CC_GT:     cond_test = ~(z | (s ^ v));
      CC_UGT:    cond_test = ~c & ~z;
      CC_NOV:    cond_test = ~v;
      CC_PL:     cond_test = ~s;
      CC_NZ:     cond_test = ~z;
      CC_NC:     cond_test = ~c;
      default:   cond_test = 1'b0;
    endcase
  endfunction : cond_test

  // fetch sequencing for modes that need register contents
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (addr_req.valid && (addr_req.mode == MODE_INDIRECT_RF || addr_req.mode == MODE_INDIRECT_PM ||
            (addr_req.mode == MODE_INDEXED && addr_req.is_load))) begin
          state_d = ST_WAIT1;
        end
      end
      ST_WAIT1: state_d = ST_DATA1;
      ST_DATA1: state_d = (req_q.mode == MODE_INDIRECT_PM) ? ST_WAIT2 : ST_IDLE;
      ST_WAIT2: state_d = ST_DATA2;
      ST_DATA2: state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d != ST_IDLE);
    end
  end

  // request capture and register file reads; the block never writes the register file
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q      <= '0;
      ptr_hi_q   <= 8'h00;
      rf_rd_q    <= 1'b0;
      rf_raddr_q <= 12'h000;
    end else begin
      rf_rd_q <= 1'b0;                                              // see RULE_09
      if (state_q == ST_IDLE && state_d == ST_WAIT1) begin
        req_q   <= addr_req;
        rf_rd_q <= 1'b1;
        if (addr_req.mode == MODE_INDEXED) begin
          rf_raddr_q <= rf_short(addr_req.wreg, register_pointer);  // see RULE_05
        end else if (addr_req.mode == MODE_INDIRECT_PM) begin
          rf_raddr_q <= rf_long({addr_req.reg8[7:1], 1'b0}, register_pointer); // see RULE_04
        end else begin
          rf_raddr_q <= rf_long(addr_req.reg8, register_pointer);   // see RULE_03
        end
      end else if (state_q == ST_DATA1 && req_q.mode == MODE_INDIRECT_PM) begin
        ptr_hi_q   <= rf_rdata;
        rf_rd_q    <= 1'b1;
        rf_raddr_q <= {rf_raddr_q[11:1], 1'b1};                    // see RULE_04
      end
    end
  end

  // address results
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_res_q <= '0;
    end else begin
      addr_res_q.done <= 1'b0;
      addr_res_q.err  <= 1'b0;
      if (state_q == ST_IDLE && addr_req.valid && state_d == ST_IDLE) begin
        addr_res_q.done <= 1'b1;
        addr_res_q.mode <= addr_req.mode;
        case (addr_req.mode)
          MODE_REG_LONG:  addr_res_q.rf_addr <= rf_long(addr_req.reg8, register_pointer);
          MODE_REG_SHORT: addr_res_q.rf_addr <= rf_short(addr_req.wreg, register_pointer);
          MODE_DIRECT:    addr_res_q.target  <= addr_req.direct;                        // see RULE_06
          MODE_RELATIVE:  addr_res_q.target  <= pc_next + {{8{addr_req.disp[7]}}, addr_req.disp}; // see RULE_07 see RULE_24
          MODE_IMMEDIATE: addr_res_q.imm     <= addr_req.imm;                           // see RULE_08
          MODE_INDEXED:   addr_res_q.err     <= 1'b1;                                   // see RULE_05
          default:        addr_res_q.err     <= 1'b1;
        endcase
      end else if (state_q == ST_DATA1 && req_q.mode != MODE_INDIRECT_PM) begin
        addr_res_q.done <= 1'b1;
        addr_res_q.mode <= req_q.mode;
        if (req_q.mode == MODE_INDEXED) begin
          addr_res_q.rf_addr <= {register_pointer[3:0], 8'(req_q.reg8 + rf_rdata)};     // see RULE_05
        end else begin
          addr_res_q.rf_addr <= {register_pointer[3:0], rf_rdata};                      // see RULE_03
        end
      end else if (state_q == ST_DATA2) begin
        addr_res_q.done    <= 1'b1;
        addr_res_q.mode    <= req_q.mode;
        addr_res_q.pm_addr <= {ptr_hi_q, rf_rdata};                                     // see RULE_04
      end
    end
  end

  // arithmetic flag computation, bits 7..2
  always_comb begin
    logic [8:0] wide;
    logic [4:0] nib;
    logic       cin;
    wide    = 9'h000;
    nib     = 5'h00;
    cin     = flag_req.use_carry & flags_q[CARRY_BIT];
    arith_d = flags_q[7:2];
    case (flag_req.op)
      FL_ADD: begin
        wide    = 9'(flag_req.a) + 9'(flag_req.b) + 9'(cin);
        nib     = 5'(flag_req.a[3:0]) + 5'(flag_req.b[3:0]) + 5'(cin);
        arith_d = {wide[8], wide[7:0] == 8'h00, wide[7],                                // see RULE_11 see RULE_12 see RULE_13
                   (flag_req.a[7] == flag_req.b[7]) && (wide[7] != flag_req.a[7]),     // see RULE_14
                   1'b0, nib[4]};                                                       // see RULE_15 see RULE_16
      end
      FL_SUB: begin
        wide    = 9'(flag_req.a) - 9'(flag_req.b) - 9'(cin);
        nib     = 5'(flag_req.a[3:0]) - 5'(flag_req.b[3:0]) - 5'(cin);
        arith_d = {wide[8], wide[7:0] == 8'h00, wide[7],                                // see RULE_11 see RULE_12 see RULE_13
                   (flag_req.a[7] != flag_req.b[7]) && (wide[7] != flag_req.a[7]),     // see RULE_14
                   1'b1, nib[4]};                                                       // see RULE_15 see RULE_16
      end
      FL_LOGIC: begin
        arith_d[ZERO_BIT-2]     = (flag_req.result == 8'h00);                           // see RULE_12
        arith_d[SIGN_BIT-2]     = flag_req.result[7];                                   // see RULE_13
        arith_d[OVERFLOW_BIT-2] = 1'b0;                                                 // see RULE_14
      end
      FL_SHIFT: begin
        arith_d[CARRY_BIT-2]    = flag_req.shift_out;                                   // see RULE_11
        arith_d[ZERO_BIT-2]     = (flag_req.result == 8'h00);
        arith_d[SIGN_BIT-2]     = flag_req.result[7];                                   // see RULE_13
        arith_d[OVERFLOW_BIT-2] = flag_req.result[7] ^ flag_req.a[7];                   // see RULE_14
      end
      FL_BITTEST: arith_d[ZERO_BIT-2]  = (flag_req.result == 8'h00);                    // see RULE_12
      FL_SET_C:   arith_d[CARRY_BIT-2] = 1'b1;                                          // see RULE_11
      FL_CLR_C:   arith_d[CARRY_BIT-2] = 1'b0;
      FL_CPL_C:   arith_d[CARRY_BIT-2] = ~flags_q[CARRY_BIT];
      default:    arith_d = flags_q[7:2];
    endcase
  end

  assign flags_wr = reg_wr_en && (reg_wr_addr == FLAGS_ADDR);                           // see RULE_10
  assign flags_q  = {arith_q, wdog_q, stop_q};

  // bits 7..2 hold their value through reset
  always_ff @(posedge clk) begin
    if (rst_n) begin                                                                    // see RULE_19
      if (flags_wr) begin
        arith_q <= reg_wr_data[7:2];                                                    // see RULE_25
      end else if (flag_req.valid) begin
        arith_q <= arith_d;
      end
    end
  end

  // watchdog and stop flags; watchdog timeout set wins over software clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdog_q <= WDOG_RESET_VAL;                                                         // see RULE_18 see RULE_19
      stop_q <= stop_wake;
    end else begin
      wdog_q <= wdog_expire | (flags_wr ? reg_wr_data[WDOG_BIT] : wdog_q);              // see RULE_18
      stop_q <= flags_wr ? reg_wr_data[STOP_BIT] : stop_q;
    end
  end

  // register read and condition outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rd_data_q <= 8'h00;
      reg_rd_hit_q  <= 1'b0;
      cond_true_q   <= 1'b0;
    end else begin
      reg_rd_hit_q  <= reg_rd_en && (reg_rd_addr == FLAGS_ADDR);
      reg_rd_data_q <= (reg_rd_en && reg_rd_addr == FLAGS_ADDR) ? flags_q : 8'h00;      // see RULE_10
      cond_true_q   <= cond_test(condition_field, flags_q);                             // see RULE_17
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_short_reg_addr: assert property (                                                   // see RULE_02
    (state_q == ST_IDLE && addr_req.valid && addr_req.mode == MODE_REG_SHORT) |=>
      addr_res_q.done && addr_res_q.rf_addr == {$past(register_pointer[3:0]), $past(register_pointer[7:4]),
                                                $past(addr_req.wreg)})
    else $error("short register address wrong");

  a_long_reg_addr: assert property (                                                    // see RULE_01
    (state_q == ST_IDLE && addr_req.valid && addr_req.mode == MODE_REG_LONG &&
     addr_req.reg8[7:4] != WORK_GROUP_TAG) |=>
      addr_res_q.rf_addr == {$past(register_pointer[3:0]), $past(addr_req.reg8)})
    else $error("long register address wrong");

  a_rel_target_wrap: assert property (                                                  // see RULE_07
    (state_q == ST_IDLE && addr_req.valid && addr_req.mode == MODE_RELATIVE) |=>
      addr_res_q.target == 16'($past(pc_next) + {{8{$past(addr_req.disp[7])}}, $past(addr_req.disp)}))
    else $error("relative target wrong");

  a_direct_target: assert property (                                                    // see RULE_06
    (state_q == ST_IDLE && addr_req.valid && addr_req.mode == MODE_DIRECT) |=>
      addr_res_q.done && addr_res_q.target == $past(addr_req.direct))
    else $error("direct target wrong");

  a_index_load_only: assert property (                                                  // see RULE_05
    (state_q == ST_IDLE && addr_req.valid && addr_req.mode == MODE_INDEXED && !addr_req.is_load) |=>
      addr_res_q.err && !rf_rd_q)
    else $error("indexed mode accepted for non-load");

  a_indirect_latency: assert property (                                                 // see RULE_03
    (state_q == ST_IDLE && addr_req.valid && addr_req.mode == MODE_INDIRECT_RF) |=>
      rf_rd_q ##1 !addr_res_q.done ##1 addr_res_q.done)
    else $error("indirect register answer late");

  a_pm_pair_even: assert property (                                                     // see RULE_04
    (state_q == ST_WAIT1 && req_q.mode == MODE_INDIRECT_PM) |-> !rf_raddr_q[0] ##2 rf_rd_q && rf_raddr_q[0])
    else $error("program memory pointer pair misaligned");

  a_write_beats_update: assert property (                                               // see RULE_25
    flags_wr |=> flags_q[7:2] == $past(reg_wr_data[7:2]))
    else $error("explicit flag write lost");

  a_logic_clears_v: assert property (                                                   // see RULE_14
    (flag_req.valid && flag_req.op == FL_LOGIC && !flags_wr) |=> !flags_q[OVERFLOW_BIT])
    else $error("overflow not cleared by logical op");

  a_sub_sets_dir: assert property (                                                     // see RULE_15
    (flag_req.valid && flag_req.op == FL_SUB && !flags_wr) |=> flags_q[DEC_DIR_BIT] &&
      ($stable(flags_q[WDOG_BIT]) || $past(wdog_expire)))
    else $error("decimal direction not set after subtract");

  a_wdog_sets: assert property (                                                        // see RULE_18
    wdog_expire |=> flags_q[WDOG_BIT])
    else $error("watchdog flag not set");

  a_reset_keeps: assert property (@(posedge clk) disable iff (1'b0)                     // see RULE_19
    (!rst_n && $past(rst_n)) |=> !flags_q[WDOG_BIT] && flags_q[7:2] == $past(flags_q[7:2]))
    else $error("reset disturbed arithmetic flags");

  c_pm_indirect:  cover property (state_q == ST_DATA2);
  c_indexed_load: cover property (state_q == ST_DATA1 && req_q.mode == MODE_INDEXED);
  c_write_vs_alu: cover property (flags_wr && flag_req.valid);
  c_wdog_vs_clr:  cover property (wdog_expire && flags_wr && !reg_wr_data[WDOG_BIT]);

endmodule : operand_addressing_and_flags

// ---- bench/rf_model.sv ----
// register file stand-in answering pointer and index fetches
`timescale 1ns/10ps
module rf_model (
  // clock
  input  wire logic        clk,
  // read port
  input  wire logic        rd,
  input  wire logic [11:0] raddr,
  output logic [7:0]       rdata
);
  function automatic logic [7:0] mem_val(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5a;
  endfunction : mem_val
  initial rdata = 8'h00;
  // byte the cycle after the strobe, scrambled otherwise
  always @(posedge clk) begin
    if (rd) rdata <= mem_val(raddr);
    else rdata <= ~rdata;
  end
endmodule : rf_model

// ---- bench/tb_operand_addressing_and_flags.sv ----
// self-checking bench for operand addressing and status flags
`timescale 1ns/10ps
module tb_operand_addressing_and_flags;
  import addressing_pkg::*;
  logic        clk, rst_n, busy_q, rf_rd_q, reg_wr_en, reg_rd_en, reg_rd_hit_q, cond_true_q, wdog_expire, stop_wake;
  logic [15:0] pc_next, w;
  logic [11:0] rf_raddr_q, reg_wr_addr, reg_rd_addr;
  logic [7:0]  register_pointer, rf_rdata, reg_wr_data, reg_rd_data_q, flags_q, ef, v;
  logic [3:0]  condition_field, pg, gr;
  logic [63:0] rnd;
  addr_req_s   q, addr_req;
  addr_res_s   addr_res_q;
  flag_req_s   flag_req;
  logic [19:0] exp_q[$];
  int          mismatches, total_checks;
  integer      seed = 32'hdef367d4;

  operand_addressing_and_flags operand_addressing_and_flags_i (
    .clk(clk), .rst_n(rst_n), .addr_req(addr_req), .pc_next(pc_next), .register_pointer(register_pointer),
    .addr_res_q(addr_res_q), .busy_q(busy_q), .rf_rd_q(rf_rd_q), .rf_raddr_q(rf_raddr_q), .rf_rdata(rf_rdata),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data_q(reg_rd_data_q), .reg_rd_hit_q(reg_rd_hit_q), .flag_req(flag_req),
    .condition_field(condition_field), .cond_true_q(cond_true_q), .wdog_expire(wdog_expire),
    .stop_wake(stop_wake), .flags_q(flags_q));
  rf_model rf_model_i (.clk(clk), .rd(rf_rd_q), .raddr(rf_raddr_q), .rdata(rf_rdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  function automatic logic [15:0] res_val(input addr_res_s r);
    if (r.mode == MODE_INDIRECT_PM) return r.pm_addr;
    if (r.mode == MODE_DIRECT || r.mode == MODE_RELATIVE) return r.target;
    if (r.mode == MODE_IMMEDIATE) return {8'h00, r.imm};
    return {4'h0, r.rf_addr};
  endfunction : res_val

  function automatic logic cond_exp(input logic [3:0] c, input logic [7:0] f);
    logic lt;
    lt = f[SIGN_BIT] ^ f[OVERFLOW_BIT];
    case (c[2:0])
      3'h0: cond_exp = 1'b0;
      3'h1: cond_exp = lt;
      3'h2: cond_exp = lt | f[ZERO_BIT];
      3'h3: cond_exp = f[CARRY_BIT] | f[ZERO_BIT];
      3'h4: cond_exp = f[OVERFLOW_BIT];
      3'h5: cond_exp = f[SIGN_BIT];
      3'h6: cond_exp = f[ZERO_BIT];
      default: cond_exp = f[CARRY_BIT];
    endcase
    return cond_exp ^ c[3];
  endfunction : cond_exp

  // a stray request is held up while busy; it must be ignored
  task automatic addr_op(input logic [19:0] ex);
    addr_req = q;
    exp_q.push_back(ex);
    @(negedge clk);
    check({19'h0_0000, busy_q}, {19'h0_0000, (q.mode inside {MODE_INDIRECT_RF, MODE_INDIRECT_PM}) ||
          (q.mode == MODE_INDEXED && q.is_load)});
    if (busy_q === 1'b1) begin
      addr_req.mode = MODE_IMMEDIATE;
      for (int i = 0; i < 20 && busy_q !== 1'b0; i++) @(negedge clk);
    end
  endtask : addr_op

  task automatic wr_flags(input logic [7:0] d, input logic [7:0] ex);
    reg_wr_en = 1'b1;
    reg_wr_data = d;
    @(negedge clk);
    {reg_wr_en, wdog_expire, flag_req.valid} = 3'h0;
    ef = ex;
    check({12'h000, flags_q}, {12'h000, ef});
  endtask : wr_flags

  task automatic fop(input flag_op_e op, input logic [7:0] x, y, input logic uc, input logic [7:0] r, input logic so);
    logic [8:0] s;
    logic       ci;
    flag_req = {1'b1, op, x, y, uc, r, so};
    ci = uc & ef[CARRY_BIT];
    s = (op == FL_SUB) ? {1'b0, x} - y - ci : x + y + ci;
    if (op == FL_ADD || op == FL_SUB) begin
      r = s[7:0];
      ef[CARRY_BIT] = s[8];
      ef[OVERFLOW_BIT] = (x[7] ^ y[7] ^ (op == FL_ADD)) & (r[7] ^ x[7]);
      ef[DEC_DIR_BIT] = (op == FL_SUB);
      ef[HALF_CARRY_BIT] = (op == FL_SUB) ? (x[3:0] < {1'b0, y[3:0]} + ci) : (x[3:0] + y[3:0] + ci > 15);
    end
    if (op == FL_SHIFT) ef[CARRY_BIT] = so;
    if (op == FL_SHIFT) ef[OVERFLOW_BIT] = x[7] ^ r[7];
    if (op == FL_LOGIC) ef[OVERFLOW_BIT] = 1'b0;
    if (op == FL_SET_C || op == FL_CLR_C) ef[CARRY_BIT] = (op == FL_SET_C);
    if (op == FL_CPL_C) ef[CARRY_BIT] = ~ef[CARRY_BIT];
    if (op inside {FL_ADD, FL_SUB, FL_LOGIC, FL_SHIFT, FL_BITTEST}) ef[ZERO_BIT] = (r == 8'h00);
    if (op inside {FL_ADD, FL_SUB, FL_LOGIC, FL_SHIFT}) ef[SIGN_BIT] = r[7];
    @(negedge clk);
    check({12'h000, flags_q}, {12'h000, ef});
  endtask : fop

  always @(posedge clk) begin
    #1;
    if (rst_n === 1'b1 && (addr_res_q.done === 1'b1 || addr_res_q.err === 1'b1))
      check(addr_res_q.err ? 20'h1_0000 : {addr_res_q.mode, 1'b0, res_val(addr_res_q)},
            exp_q.size() > 0 ? exp_q.pop_front() : 20'hf_ffff);
  end

  initial begin
    #200_000;
    mismatches++;
    results();
  end

  initial begin
    {rst_n, reg_wr_en, reg_rd_en, wdog_expire, stop_wake} = 5'h00;
    {addr_req, flag_req, pc_next, register_pointer, condition_field, reg_wr_data, reg_rd_addr} = '0;
    reg_wr_addr = FLAGS_ADDR;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check({18'h0_0000, flags_q[1:0]}, 20'h0_0000);
    for (int n = 0; n < 48; n++) begin
      rnd = {$random(seed), $random(seed)};
      q = rnd[48:0];
      q.valid = 1'b1;
      q.mode = addr_mode_e'(n % 8);
      q.is_load = (n != 12);
      q.reg8[7:4] = (n == 16) ? WORK_GROUP_TAG : {1'b0, q.reg8[6:4]};
      if (n == 6) q.disp = 8'h80;
      if (n == 14) q.disp = 8'h7f;
      register_pointer = {1'b0, rnd[55:49]};
      pc_next = (n == 14) ? 16'hfff0 : rnd[63:48];
      pg = register_pointer[3:0];
      gr = register_pointer[7:4];
      case (q.mode)
        MODE_REG_LONG:    w = {4'h0, pg, (q.reg8[7:4] == WORK_GROUP_TAG) ? {gr, q.reg8[3:0]} : q.reg8};
        MODE_REG_SHORT:   w = {4'h0, pg, gr, q.wreg};
        MODE_INDIRECT_RF: w = {4'h0, pg, rf_model_i.mem_val({pg, q.reg8})};
        MODE_INDIRECT_PM: w = {rf_model_i.mem_val({pg, q.reg8[7:1], 1'b0}),
                               rf_model_i.mem_val({pg, q.reg8[7:1], 1'b1})};
        MODE_INDEXED:     w = {4'h0, pg, q.reg8 + rf_model_i.mem_val({pg, gr, q.wreg})};
        MODE_DIRECT:      w = q.direct;
        MODE_RELATIVE:    w = pc_next + {{8{q.disp[7]}}, q.disp};
        default:          w = {8'h00, q.imm};
      endcase
      addr_op((q.mode == MODE_INDEXED && !q.is_load) ? 20'h1_0000 : {q.mode, 1'b0, w});
    end
    addr_req.valid = 1'b0;
    repeat (2) @(negedge clk);
    check(20'(exp_q.size()), 20'h0_0000);
    wr_flags(8'h00, 8'h00);
    fop(FL_ADD, 8'h7f, 8'h01, 1'b0, 8'h00, 1'b0);
    fop(FL_SUB, 8'h80, 8'h01, 1'b0, 8'h00, 1'b0);
    for (int n = 0; n < 64; n++) begin
      rnd = {$random(seed), $random(seed)};
      fop(flag_op_e'(1 + rnd[63:61]), rnd[7:0], rnd[15:8], rnd[16], rnd[23:16], rnd[24]);
    end
    flag_req = {1'b1, FL_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 1'b0};
    wdog_expire = 1'b1;
    wr_flags(8'h3c, 8'h3e);
    @(negedge clk);
    check({12'h000, flags_q}, 20'h0_003e);
    stop_wake = 1'b1;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    {rst_n, stop_wake} = 2'h2;
    check({12'h000, flags_q}, {12'h000, ef[7:2], 2'h1});
    wr_flags(8'h3c, 8'h3c);
    for (int n = 0; n < 3; n++) begin
      reg_rd_en = 1'b1;
      reg_rd_addr = (n == 0) ? FLAGS_ADDR : (n == 1) ? 12'h0fd : 12'h1fc;
      @(negedge clk);
      check({11'h000, reg_rd_hit_q, reg_rd_data_q}, (n == 0) ? {12'h001, ef} : 20'h0_0000);
    end
    reg_rd_en = 1'b0;
    for (int n = 0; n < 128; n++) begin
      v = $random(seed);
      if (n % 16 == 0) wr_flags(v, v);
      condition_field = n[3:0];
      @(negedge clk);
      check({19'h0_0000, cond_true_q}, {19'h0_0000, cond_exp(n[3:0], ef)});
    end
    results();
  end
endmodule : tb_operand_addressing_and_flags
